/* hw/ccr_params.svh */
// Offsets, reset values, field positions and limits of the charger configuration slice.
// Assumes it is included by bare name from the register block and the test bench.
`ifndef CCR_PARAMS_SVH
`define CCR_PARAMS_SVH

// ----------------------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------------------
`define CCR_OFS_WDOG_KICK 8'h03
`define CCR_OFS_CHG_CURRENT 8'h04
`define CCR_OFS_PRE_TERM 8'h05
`define CCR_OFS_CHG_VOLTAGE 8'h06
`define CCR_OFS_TERM_TIMER 8'h07
`define CCR_OFS_PULSE_REQ 8'h09

// ----------------------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------------------
`define CCR_RST_CHG_CURRENT 8'h20
`define CCR_RST_PRE_TERM 8'h13
`define CCR_RST_CHG_VOLTAGE 8'h5E
`define CCR_RST_TERM_TIMER 8'h9D

// ----------------------------------------------------------------------------
// Field positions and limits
// ----------------------------------------------------------------------------
`define CCR_BIT_PULSE_EN 7
`define CCR_BIT_KICK 6
`define CCR_BIT_PULSE_UP 1
`define CCR_BIT_PULSE_DN 0
`define CCR_BIT_RESERVED 0
`define CCR_FAST_CUR_MAX 7'h4F
`define CCR_VLIM_MAX 6'h30
// Bus target address; the value is arbitrary.
`define CCR_DEV_ADDR 7'h2C

`endif

/* hw/ccr_pkg.sv */
// Types shared by the charger configuration slice.
// Assumes nothing beyond the parameter header.
package ccr_pkg;
	typedef enum logic [6:0] {
		CCR_IDLE = 7'h01,
		CCR_ADDR = 7'h02,
		CCR_ACK_ADDR = 7'h04,
		CCR_WR = 7'h08,
		CCR_ACK_WR = 7'h10,
		CCR_RD = 7'h20,
		CCR_ACK_RD = 7'h40
	} ccr_state_type;
endpackage

/* hw/ccr_sync.sv */
// Two-flop synchroniser, one chain per bit.
// Assumes inputs arrive asynchronously from pins.
`timescale 1ns/10ps
module ccr_sync #(
	parameter int WIDTH = 2
) (
	input wire logic clk_sys_i,
	input wire logic resetn_i,
	input wire logic [WIDTH-1:0] async_i,
	output logic [WIDTH-1:0] sync_o
);
	logic [WIDTH-1:0] meta_q;
	logic [WIDTH-1:0] sync_q;

	// Idle bus lines are high, so the chains come out of reset high.
	for (genvar i = 0; i < WIDTH; i++) begin : g_bit
		always_ff @(posedge clk_sys_i) begin
			if (!resetn_i) begin
				meta_q[i] <= 1'b1;
				sync_q[i] <= 1'b1;
			end else begin
				meta_q[i] <= async_i[i];
				sync_q[i] <= meta_q[i];
			end
		end
	end

	assign sync_o = sync_q;
endmodule

/* hw/ccr_clamp.sv */
// Saturating limiter for a written field code.
// Assumes an unsigned code and an unsigned ceiling of the same width.
`timescale 1ns/10ps
module ccr_clamp #(
	parameter int WIDTH = 7
) (
	input wire logic [WIDTH-1:0] code_i,
	input wire logic [WIDTH-1:0] max_i,
	output logic [WIDTH-1:0] code_o
);
	assign code_o = (code_i > max_i) ? max_i : code_i;
endmodule

/* hw/ccr_regs.sv */
// Charger configuration registers 0x04 to 0x07 behind a two-wire bus target.
// Assumes open-drain bus lines resolved outside, and engine events on clk_sys_i.
//
// What this block does
// - Charge-current bit 7 enables pulse control; zero refuses pulse requests.
// - Charge-current bits 6:0 hold fast-charge code, 64mA LSB, reset 2048mA.
// - A fast-charge code of zero disables charging.
// - Fast-charge codes above 1001111 are clamped to 1001111.
// - Threshold bits 7:4 hold precharge current, 64mA offset, reset 0001.
// - Threshold bits 3:0 hold termination current, 64mA offset, reset 0011.
// - Voltage bits 7:2 hold charge limit, 3.840V offset, 16mV LSB, reset 010111.
// - Charge voltage codes above 110000 are clamped to 110000.
// - Voltage bit 1 picks precharge-to-fast threshold 2.8V or 3.0V, reset 1.
// - Voltage bit 0 picks recharge offset 100mV or 200mV, reset 0.
// - Timer-control bit 7 enables termination, reset 1.
// - Timer-control bit 6 disables the status pin, reset 0.
// - Timer-control bits 5:4 pick watchdog period, off/40s/80s/160s, reset 01.
// - Timer-control bit 3 enables the safety timer, reset 1.
// - Timer-control bits 2:1 pick fast-charge timer 5/8/12/20 hrs, reset 10.
// - Timer-control bit 0 is reserved and always reads 1.
// - Pulse requests set only while enabled; each clears when its sequence ends.
// - Host writes 1 to kick the watchdog; the bit returns to 0 itself.
`timescale 1ns/10ps
`include "ccr_params.svh"
module ccr_regs
	import ccr_pkg::*;
(
	input wire logic clk_sys_i,
	input wire logic resetn_i,
	input wire logic scl_i,
	input wire logic sda_i,
	output logic sda_o,
	output logic sda_oe_o,
	input wire logic reg_reset_req_i,
	input wire logic watchdog_expired_i,
	input wire logic pulse_up_done_i,
	input wire logic pulse_down_done_i,
	output logic pulse_ctrl_enable_o,
	output logic pulse_voltage_up_req_o,
	output logic pulse_voltage_down_req_o,
	output logic [6:0] fast_charge_current_o,
	output logic charge_enable_o,
	output logic [3:0] precharge_current_o,
	output logic [3:0] termination_current_o,
	output logic [5:0] charge_voltage_limit_o,
	output logic precharge_to_fast_threshold_o,
	output logic recharge_offset_select_o,
	output logic termination_enable_o,
	output logic status_pin_disable_o,
	output logic [1:0] watchdog_period_o,
	output logic safety_timer_enable_o,
	output logic [1:0] fast_charge_timer_o,
	output logic watchdog_kick_o
);
	// ------------------------------------------------------------------------
	// Bus line sampling
	// ------------------------------------------------------------------------
	logic [1:0] line_s;
	logic scl_s;
	logic sda_s;
	logic scl_prev_q;
	logic sda_prev_q;
	logic scl_rise_w;
	logic scl_fall_w;
	logic start_w;
	logic stop_w;

	ccr_sync #(.WIDTH(2)) u_sync (
		.clk_sys_i(clk_sys_i),
		.resetn_i(resetn_i),
		.async_i({scl_i, sda_i}),
		.sync_o(line_s)
	);

	assign scl_s = line_s[1];
	assign sda_s = line_s[0];

	always_ff @(posedge clk_sys_i) begin
		if (!resetn_i) begin
			scl_prev_q <= 1'b1;
			sda_prev_q <= 1'b1;
		end else begin
			scl_prev_q <= scl_s;
			sda_prev_q <= sda_s;
		end
	end

	assign scl_rise_w = scl_s & ~scl_prev_q;
	assign scl_fall_w = ~scl_s & scl_prev_q;
	assign start_w = scl_s & scl_prev_q & sda_prev_q & ~sda_s;
	assign stop_w = scl_s & scl_prev_q & ~sda_prev_q & sda_s;

	// ------------------------------------------------------------------------
	// Bus target state machine
	// ------------------------------------------------------------------------
	ccr_state_type state_q;
	logic [3:0] bit_cnt_q;
	logic [7:0] shift_q;
	logic [7:0] ptr_q;
	logic rw_q;
	logic first_q;
	logic oe_q;
	logic [7:0] rd_byte_w;
	logic [7:0] ptr_inc_w;
	logic [7:0] shift_in_w;
	logic byte_done_w;

	assign ptr_inc_w = ptr_q + 8'h01;
	assign shift_in_w = {shift_q[6:0], sda_s};
	assign byte_done_w = scl_fall_w && (bit_cnt_q == 4'h8);

	// The pointer moves on after every byte, so bursts walk the map in order.
	always_ff @(posedge clk_sys_i) begin
		if (!resetn_i) begin
			state_q <= CCR_IDLE;
			bit_cnt_q <= 4'h0;
			shift_q <= 8'h00;
			ptr_q <= 8'h00;
			rw_q <= 1'b0;
			first_q <= 1'b0;
			oe_q <= 1'b0;
		end else if (start_w) begin
			state_q <= CCR_ADDR;
			bit_cnt_q <= 4'h0;
			oe_q <= 1'b0;
		end else if (stop_w) begin
			state_q <= CCR_IDLE;
			oe_q <= 1'b0;
		end else begin
			case (state_q)
				CCR_ADDR, CCR_WR: begin
					if (scl_rise_w) begin
						shift_q <= shift_in_w;
						bit_cnt_q <= bit_cnt_q + 4'h1;
					end else if (byte_done_w) begin
						bit_cnt_q <= 4'h0;
						if (state_q == CCR_WR) begin
							state_q <= CCR_ACK_WR;
							oe_q <= 1'b1;
							first_q <= 1'b0;
							ptr_q <= first_q ? shift_q : ptr_inc_w;
						end else if (shift_q[7:1] == `CCR_DEV_ADDR) begin
							state_q <= CCR_ACK_ADDR;
							oe_q <= 1'b1;
							rw_q <= shift_q[0];
							first_q <= ~shift_q[0];
						end else begin
							state_q <= CCR_IDLE;
						end
					end
				end
				CCR_ACK_ADDR, CCR_ACK_WR: begin
					if (scl_fall_w && (state_q == CCR_ACK_ADDR) && rw_q) begin
						state_q <= CCR_RD;
						shift_q <= rd_byte_w;
						ptr_q <= ptr_inc_w;
						oe_q <= ~rd_byte_w[7];
					end else if (scl_fall_w) begin
						state_q <= CCR_WR;
						oe_q <= 1'b0;
					end
				end
				CCR_RD: begin
					if (scl_fall_w && (bit_cnt_q == 4'h7)) begin
						state_q <= CCR_ACK_RD;
						bit_cnt_q <= 4'h0;
						oe_q <= 1'b0;
					end else if (scl_fall_w) begin
						bit_cnt_q <= bit_cnt_q + 4'h1;
						shift_q <= {shift_q[6:0], 1'b0};
						oe_q <= ~shift_q[6];
					end
				end
				CCR_ACK_RD: begin
					// A high line at the controller's acknowledge ends the read.
					if (scl_rise_w && sda_s) begin
						state_q <= CCR_IDLE;
					end else if (scl_fall_w) begin
						state_q <= CCR_RD;
						shift_q <= rd_byte_w;
						ptr_q <= ptr_inc_w;
						oe_q <= ~rd_byte_w[7];
					end
				end
				default: begin
					state_q <= CCR_IDLE;
				end
			endcase
		end
	end

	assign sda_o = 1'b0;
	assign sda_oe_o = oe_q;

	// ------------------------------------------------------------------------
	// Register write decode
	// ------------------------------------------------------------------------
	logic wr_stb_w;
	logic [7:0] wr_data_w;
	logic load_def_w;
	logic wr_cc_w;
	logic wr_pt_w;
	logic wr_cv_w;
	logic wr_tt_w;
	logic wr_pulse_w;
	logic [6:0] fcc_cl_w;
	logic [5:0] vlim_cl_w;

	assign wr_stb_w = (state_q == CCR_WR) && byte_done_w && !first_q && !start_w && !stop_w;
	assign wr_data_w = shift_q;
	assign load_def_w = reg_reset_req_i | watchdog_expired_i;
	assign wr_cc_w = wr_stb_w && (ptr_q == `CCR_OFS_CHG_CURRENT);
	assign wr_pt_w = wr_stb_w && (ptr_q == `CCR_OFS_PRE_TERM);
	assign wr_cv_w = wr_stb_w && (ptr_q == `CCR_OFS_CHG_VOLTAGE);
	assign wr_tt_w = wr_stb_w && (ptr_q == `CCR_OFS_TERM_TIMER);
	assign wr_pulse_w = wr_stb_w && (ptr_q == `CCR_OFS_PULSE_REQ);

	ccr_clamp #(.WIDTH(7)) u_fcc_clamp (
		.code_i(wr_data_w[6:0]),
		.max_i(`CCR_FAST_CUR_MAX),
		.code_o(fcc_cl_w)
	);

	ccr_clamp #(.WIDTH(6)) u_vlim_clamp (
		.code_i(wr_data_w[7:2]),
		.max_i(`CCR_VLIM_MAX),
		.code_o(vlim_cl_w)
	);

	// ------------------------------------------------------------------------
	// Configuration registers
	// ------------------------------------------------------------------------
	logic [7:0] cc_q;
	logic [7:0] cc_d;
	logic [7:0] pt_q;
	logic [7:0] pt_d;
	logic [7:0] cv_q;
	logic [7:0] cv_d;
	logic [7:1] tt_q;
	logic [7:1] tt_d;
	logic [7:0] tt_rst_w;
	logic charge_en_q;
	logic up_q;
	logic dn_q;
	logic up_d;
	logic dn_d;
	logic kick_q;
	logic kick_d;
	logic set_up_w;
	logic set_dn_w;

	assign tt_rst_w = `CCR_RST_TERM_TIMER;

	// defaults on register reset or expiry
	assign cc_d = load_def_w ? `CCR_RST_CHG_CURRENT :
		wr_cc_w ? {wr_data_w[`CCR_BIT_PULSE_EN], fcc_cl_w} : cc_q;
	assign pt_d = load_def_w ? `CCR_RST_PRE_TERM : wr_pt_w ? wr_data_w : pt_q;
	assign cv_d = load_def_w ? `CCR_RST_CHG_VOLTAGE :
		wr_cv_w ? {vlim_cl_w, wr_data_w[1:0]} : cv_q;
	assign tt_d = load_def_w ? tt_rst_w[7:1] : wr_tt_w ? wr_data_w[7:1] : tt_q;

	assign set_up_w = wr_pulse_w && wr_data_w[`CCR_BIT_PULSE_UP] && cc_q[`CCR_BIT_PULSE_EN];
	assign set_dn_w = wr_pulse_w && wr_data_w[`CCR_BIT_PULSE_DN] && cc_q[`CCR_BIT_PULSE_EN];
	// A set that lands with the completion wins, so a completion never drops a fresh request.
	assign up_d = load_def_w ? 1'b0 : (up_q & ~pulse_up_done_i) | set_up_w;
	assign dn_d = load_def_w ? 1'b0 : (dn_q & ~pulse_down_done_i) | set_dn_w;
	assign kick_d = !load_def_w && wr_stb_w && (ptr_q == `CCR_OFS_WDOG_KICK) &&
		wr_data_w[`CCR_BIT_KICK];

	always_ff @(posedge clk_sys_i) begin
		if (!resetn_i) begin
			cc_q <= `CCR_RST_CHG_CURRENT;
			pt_q <= `CCR_RST_PRE_TERM;
			cv_q <= `CCR_RST_CHG_VOLTAGE;
			tt_q <= tt_rst_w[7:1];
			charge_en_q <= 1'b1;
			up_q <= 1'b0;
			dn_q <= 1'b0;
			kick_q <= 1'b0;
		end else begin
			cc_q <= cc_d;
			pt_q <= pt_d;
			cv_q <= cv_d;
			tt_q <= tt_d;
			charge_en_q <= (cc_d[6:0] != 7'h00);
			up_q <= up_d;
			dn_q <= dn_d;
			kick_q <= kick_d;
		end
	end

	assign rd_byte_w = (ptr_q == `CCR_OFS_CHG_CURRENT) ? cc_q :
		(ptr_q == `CCR_OFS_PRE_TERM) ? pt_q :
		(ptr_q == `CCR_OFS_CHG_VOLTAGE) ? cv_q :
		(ptr_q == `CCR_OFS_TERM_TIMER) ? {tt_q, 1'b1} :
		(ptr_q == `CCR_OFS_WDOG_KICK) ? {1'b0, kick_q, 6'h00} :
		(ptr_q == `CCR_OFS_PULSE_REQ) ? {6'h00, up_q, dn_q} : 8'h00;

	assign pulse_ctrl_enable_o = cc_q[`CCR_BIT_PULSE_EN];
	assign fast_charge_current_o = cc_q[6:0];
	assign charge_enable_o = charge_en_q;
	assign precharge_current_o = pt_q[7:4];
	assign termination_current_o = pt_q[3:0];
	assign charge_voltage_limit_o = cv_q[7:2];
	assign precharge_to_fast_threshold_o = cv_q[1];
	assign recharge_offset_select_o = cv_q[0];
	assign termination_enable_o = tt_q[7];
	assign status_pin_disable_o = tt_q[6];
	assign watchdog_period_o = tt_q[5:4];
	assign safety_timer_enable_o = tt_q[3];
	assign fast_charge_timer_o = tt_q[2:1];
	assign pulse_voltage_up_req_o = up_q;
	assign pulse_voltage_down_req_o = dn_q;
	assign watchdog_kick_o = kick_q;

	// ------------------------------------------------------------------------
	// Checks
	// ------------------------------------------------------------------------
	default clocking cb @(posedge clk_sys_i); endclocking
	default disable iff (!resetn_i);

	sequence s_cc_big;
		wr_cc_w && (wr_data_w[6:0] > `CCR_FAST_CUR_MAX) && !load_def_w;
	endsequence
	sequence s_cv_big;
		wr_cv_w && (wr_data_w[7:2] > `CCR_VLIM_MAX) && !load_def_w;
	endsequence

	chk_fcc_clamp: assert property (s_cc_big |=> fast_charge_current_o == 7'h4F)
		else $error("fast-charge code not clamped");
	chk_vlim_clamp: assert property (s_cv_big |=> charge_voltage_limit_o == 6'h30)
		else $error("charge voltage code not clamped");
	chk_pulse_refused: assert property ($rose(up_q) |-> $past(cc_q[7]))
		else $error("pulse request set while disabled");
	chk_pulse_done: assert property (up_q && pulse_up_done_i && !wr_pulse_w |=> !up_q)
		else $error("pulse request did not clear on completion");
	chk_kick_clear: assert property (watchdog_kick_o |=> !watchdog_kick_o)
		else $error("watchdog kick bit stuck high");
	chk_default_load: assert property (load_def_w |=> cc_q == 8'h20 && pt_q == 8'h13
		&& cv_q == 8'h5E && tt_q == 7'h4E && !up_q && !dn_q)
		else $error("fields not restored to defaults");
	chk_charge_off: assert property (wr_cc_w && wr_data_w[6:0] == 7'h00 && !load_def_w
		|=> !charge_enable_o)
		else $error("zero code left charging enabled");
	// While the last bit of the byte from 0x07 is shifted out, the line must stay released.
	chk_reserved_one: assert property (state_q == CCR_RD && bit_cnt_q == 4'h7
		&& ptr_q == 8'h08 |-> !oe_q)
		else $error("reserved bit did not read one");
	chk_vlim_write: assert property (wr_cv_w && !load_def_w && wr_data_w[7:2] <= 6'h30
		|=> charge_voltage_limit_o == $past(wr_data_w[7:2]) ##1 $stable(cv_q)
		|| $past(load_def_w) || $past(wr_cv_w))
		else $error("charge voltage write lost");
	chk_timer_write: assert property (wr_tt_w && !load_def_w |=>
		{watchdog_period_o, fast_charge_timer_o} == {$past(wr_data_w[5:4]),
		$past(wr_data_w[2:1])})
		else $error("timer control write lost");
endmodule

/* test/ccr_host.sv */
// Two-wire bus controller model standing in for the host processor.
// Assumes pull-ups on both lines; the device pulls data low through dev_pull_i.
`timescale 1ns/10ps
module ccr_host (
	input wire logic clk_i,
	input wire logic dev_pull_i,
	output logic scl_o,
	output logic sda_o
);
	logic pull_q;

	// Open drain with pull-up: the line is low while either party pulls it.
	assign sda_o = ~(pull_q | dev_pull_i);

	initial begin
		scl_o = 1'b1;
		pull_q = 1'b0;
	end

	// Half a bus clock period, well above the device's five-cycle minimum.
	task automatic hp();
		repeat (10) @(posedge clk_i);
		#1;
	endtask

	// Serves as a repeated start too, so data is released before the clock rises.
	task automatic start();
		pull_q = 1'b0;
		hp();
		scl_o = 1'b1;
		hp();
		pull_q = 1'b1;
		hp();
		scl_o = 1'b0;
	endtask

	task automatic stop();
		pull_q = 1'b1;
		hp();
		scl_o = 1'b1;
		hp();
		pull_q = 1'b0;
		hp();
	endtask

	// Sends tx MSB first while sampling the line into rx; host_ack pulls the ninth bit.
	task automatic byte_io(input logic [7:0] tx, output logic [7:0] rx,
		input logic host_ack, output logic dev_ack);
		for (int i = 7; i >= 0; i--) begin
			pull_q = ~tx[i];
			hp();
			scl_o = 1'b1;
			rx[i] = sda_o;
			hp();
			scl_o = 1'b0;
		end
		pull_q = host_ack;
		hp();
		scl_o = 1'b1;
		dev_ack = ~sda_o;
		hp();
		scl_o = 1'b0;
	endtask
endmodule

/* test/ccr_regs_test.sv */
// Self-checking bench for the charger configuration registers.
// Assumes the host model on the bus and the engine pulses driven here.
`timescale 1ns/10ps
`include "ccr_params.svh"
module ccr_regs_test;
	logic clk = 1'b0, rstn = 1'b0, rrst = 1'b0, wexp = 1'b0, upd = 1'b0, dnd = 1'b0;
	logic scl, sda, sdo, sdoe, pen, pup, pdn, chen, thr, rof, ten, sdis, sten, kick, a;
	logic [6:0] fcc;
	logic [3:0] ipre, iend;
	logic [5:0] vlim;
	logic [1:0] wdp, tmr;
	logic [7:0] x8;
	logic [31:0] rd;
	int bad_count = 0, n_checks = 0, kicks = 0;
	// Field outputs packed as registers 0x04 to 0x07, reserved bit included.
	wire [31:0] outs = {pen, fcc, ipre, iend, vlim, thr, rof, ten, sdis, wdp, sten, tmr, 1'b1};

	always #12.5 clk = ~clk;
	always @(posedge clk) if (kick) kicks++;

	ccr_host host (.clk_i(clk), .dev_pull_i(sdoe & ~sdo), .scl_o(scl), .sda_o(sda));
	ccr_regs dut (.clk_sys_i(clk), .resetn_i(rstn), .scl_i(scl), .sda_i(sda), .sda_o(sdo),
		.sda_oe_o(sdoe), .reg_reset_req_i(rrst), .watchdog_expired_i(wexp),
		.pulse_up_done_i(upd), .pulse_down_done_i(dnd), .pulse_ctrl_enable_o(pen),
		.pulse_voltage_up_req_o(pup), .pulse_voltage_down_req_o(pdn),
		.fast_charge_current_o(fcc), .charge_enable_o(chen), .precharge_current_o(ipre),
		.termination_current_o(iend), .charge_voltage_limit_o(vlim),
		.precharge_to_fast_threshold_o(thr), .recharge_offset_select_o(rof),
		.termination_enable_o(ten), .status_pin_disable_o(sdis), .watchdog_period_o(wdp),
		.safety_timer_enable_o(sten), .fast_charge_timer_o(tmr), .watchdog_kick_o(kick));

	// ----
	// Bus access and checking tasks
	// ----
	task automatic chk(string nm, logic [31:0] e, logic [31:0] g);
		n_checks++;
		if (g !== e) begin
			bad_count++;
			$display("[ERR] %s expected %h seen %h", nm, e, g);
		end
	endtask

	task automatic wr(logic [7:0] p, logic [7:0] d);
		logic [7:0] x;
		logic a1, a2, a3;
		host.start();
		host.byte_io({`CCR_DEV_ADDR, 1'b0}, x, 1'b0, a1);
		host.byte_io(p, x, 1'b0, a2);
		host.byte_io(d, x, 1'b0, a3);
		host.stop();
		chk("write ack", 32'h7, {a1, a2, a3});
	endtask

	// Reads n bytes from pointer p into rd, the first byte most significant.
	task automatic rdn(logic [7:0] p, int n);
		logic [7:0] x;
		logic a1, a2, a3;
		host.start();
		host.byte_io({`CCR_DEV_ADDR, 1'b0}, x, 1'b0, a1);
		host.byte_io(p, x, 1'b0, a2);
		host.start();
		host.byte_io({`CCR_DEV_ADDR, 1'b1}, x, 1'b0, a3);
		chk("read ack", 32'h7, {a1, a2, a3});
		rd = '0;
		for (int i = n; i > 0; i--) begin
			host.byte_io(8'hFF, x, i > 1, a1);
			rd = {rd[23:0], x};
		end
		host.stop();
	endtask

	// Writes the four registers one by one, then checks readback and field outputs.
	task automatic cfg(logic [31:0] w, logic [31:0] e);
		for (int i = 0; i < 4; i++) wr(8'(4 + i), w[31 - 8 * i -: 8]);
		rdn(8'h04, 4);
		chk("readback", e, rd);
		chk("fields", e, outs);
	endtask

	task automatic tick(ref logic s);
		@(posedge clk);
		#1 s = 1'b1;
		@(posedge clk);
		#1 s = 1'b0;
		@(posedge clk);
		#1;
	endtask

	task automatic summarize();
		$display("checks %0d mismatches %0d", n_checks, bad_count);
		if (bad_count == 0 && n_checks > 0) begin
			$display("bench passed");
		end else begin
			$display("bench failed");
		end
		$finish;
	endtask

	// ----
	// Test sequence
	// ----
	initial begin
		repeat (12) @(posedge clk);
		#1 rstn = 1'b1;
		rdn(8'h04, 4);
		chk("defaults", 32'h2013_5E9D, rd); // defaults
		chk("default fields", 32'h2013_5E9D, outs); // defaults
		chk("charge enable", 32'h1, chen); // nonzero code
		cfg(32'h4F5A_C249, 32'h4F5A_C249); // limits kept
		cfg(32'h50A5_C500, 32'h4FA5_C101); // clamped
		wr(8'h09, 8'h03); // request while disabled
		chk("refused requests", 32'h0, {pup, pdn}); // refused
		cfg(32'hFFFF_FFFE, 32'hCFFF_C3FF); // all ones
		wr(8'h09, 8'h03); // request while enabled
		rdn(8'h09, 1);
		chk("request bits", 32'h3, rd); // accepted
		tick(upd);
		chk("up done", 32'h1, {pup, pdn}); // up cleared
		tick(dnd);
		chk("down done", 32'h0, {pup, pdn}); // down cleared
		cfg(32'h8000_01A2, 32'h8000_01A3); // other codes
		chk("charge disabled", 32'h0, chen); // zero code
		wr(8'h03, 8'h40); // kick written
		chk("kick pulses", 32'h1, kicks); // one pulse
		rdn(8'h03, 1);
		chk("kick reads", 32'h0, rd); // self cleared
		wr(8'h09, 8'h03);
		tick(rrst);
		rdn(8'h04, 4);
		chk("soft reset", 32'h2013_5E9D, rd); // register reset
		chk("soft reset reqs", 32'h0, {pup, pdn}); // requests dropped
		cfg(32'h4F5A_C249, 32'h4F5A_C249);
		tick(wexp);
		rdn(8'h04, 4);
		chk("expiry reset", 32'h2013_5E9D, outs); // watchdog expiry
		chk("expiry readback", 32'h2013_5E9D, rd); // readback after expiry
		chk("expiry charge enable", 32'h1, chen); // default code charges
		rdn(8'h0A, 1);
		chk("unmapped", 32'h0, rd); // unlisted reads zero
		host.start();
		host.byte_io({`CCR_DEV_ADDR ^ 7'h01, 1'b0}, x8, 1'b0, a);
		host.stop();
		chk("foreign address ack", 32'h0, a); // other target ignored
		summarize();
	end

	// Around 30k cycles are expected; this limit leaves ample margin.
	initial begin
		#2_000_000;
		bad_count++;
		$display("[ERR] run expected done seen timeout");
		summarize();
	end
endmodule
